/* File: shared/lane_map_pkg.sv */
/*
 * Constants, types and per-format tables for the quad-channel lane mapper.
 * Assumes 12-bit samples from the converter cores, MSB at bit 11.
 */
package lane_map_pkg;

    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int CHANNELS  = 4;
    localparam int LANES     = 8;
    localparam int MAX_DEPTH = 8;
    localparam int SAMPLE_W  = 12;
    localparam int FRAME_W   = 40;   // Five octets, the longest lane frame
    localparam int FMT_W     = 4;
    localparam int DEPTH_W   = 4;
    localparam int OCTET_W   = 3;
    localparam int PACK_W    = 96;   // Contiguous stream for packed formats
    localparam int SLICE_W   = 16;   // Two octets per lane when packed

    // ------------------------------------------------------------
    // Format codes
    // ------------------------------------------------------------
    localparam logic [FMT_W-1:0] FMT_R12_8B_L6  = 4'h0;
    localparam logic [FMT_W-1:0] FMT_R12_64B_L6 = 4'h1;
    localparam logic [FMT_W-1:0] FMT_R8_8B_L4   = 4'h2;
    localparam logic [FMT_W-1:0] FMT_R8_64B_L4  = 4'h3;
    localparam logic [FMT_W-1:0] FMT_R10_8B_L4  = 4'h4;
    localparam logic [FMT_W-1:0] FMT_R12_64B_L3 = 4'h5;
    localparam logic [FMT_W-1:0] FMT_R8_64B_L2  = 4'h6;
    localparam logic [FMT_W-1:0] FMT_R12_64B_L4 = 4'h7;
    localparam logic [FMT_W-1:0] FMT_R8_8B_L8   = 4'h8;
    localparam logic [FMT_W-1:0] FMT_R10_8B_L8  = 4'h9;
    localparam logic [FMT_W-1:0] FMT_COUNT      = 4'hA;
    localparam logic [FMT_W-1:0] FMT_RESET      = FMT_R12_8B_L6;

    // Resolution cut: LSB position kept from a 12-bit sample
    localparam int R8_LSB  = 4;
    localparam int R10_LSB = 2;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef logic [SAMPLE_W-1:0]      sample_t;
    typedef sample_t [MAX_DEPTH-1:0]  chan_bank_t;
    typedef chan_bank_t [CHANNELS-1:0] bank_t;
    typedef sample_t [CHANNELS-1:0]   instant_t;
    typedef logic [FRAME_W-1:0]       lane_word_t;
    typedef lane_word_t [LANES-1:0]   lane_set_t;

    function automatic logic [7:0] cut8(input sample_t s);
        cut8 = s[SAMPLE_W-1:R8_LSB];
    endfunction

    function automatic logic [9:0] cut10(input sample_t s);
        cut10 = s[SAMPLE_W-1:R10_LSB];
    endfunction

    // Sampling instants per channel per frame; zero marks a bad code
    function automatic logic [DEPTH_W-1:0] depth_of(input logic [FMT_W-1:0] f);
        case (f)
            FMT_R12_8B_L6, FMT_R12_64B_L6: depth_of = 4'h2;
            FMT_R8_8B_L4, FMT_R8_64B_L4:   depth_of = 4'h1;
            FMT_R10_8B_L4:                 depth_of = 4'h4;
            FMT_R12_64B_L3, FMT_R8_64B_L2: depth_of = 4'h1;
            FMT_R12_64B_L4, FMT_R8_8B_L8:  depth_of = 4'h2;
            FMT_R10_8B_L8:                 depth_of = 4'h8;
            default:                       depth_of = 4'h0;
        endcase
    endfunction

    function automatic logic [3:0] lanes_of(input logic [FMT_W-1:0] f);
        case (f)
            FMT_R12_8B_L6, FMT_R12_64B_L6: lanes_of = 4'h6;
            FMT_R8_8B_L4, FMT_R8_64B_L4:   lanes_of = 4'h4;
            FMT_R10_8B_L4, FMT_R12_64B_L4: lanes_of = 4'h4;
            FMT_R12_64B_L3:                lanes_of = 4'h3;
            FMT_R8_64B_L2:                 lanes_of = 4'h2;
            FMT_R8_8B_L8, FMT_R10_8B_L8:   lanes_of = 4'h8;
            default:                       lanes_of = 4'h0;
        endcase
    endfunction

    function automatic logic [OCTET_W-1:0] octets_of(input logic [FMT_W-1:0] f);
        case (f)
            FMT_R12_8B_L6, FMT_R12_64B_L6: octets_of = 3'h2;
            FMT_R12_64B_L3, FMT_R8_64B_L2: octets_of = 3'h2;
            FMT_R8_8B_L4, FMT_R8_64B_L4:   octets_of = 3'h1;
            FMT_R8_8B_L8:                  octets_of = 3'h1;
            FMT_R10_8B_L4, FMT_R10_8B_L8:  octets_of = 3'h5;
            FMT_R12_64B_L4:                octets_of = 3'h3;
            default:                       octets_of = 3'h0;
        endcase
    endfunction

endpackage

/* File: shared/sample_bank_if.sv */
/*
 * Carrier between the lane mapper and its sample gatherer.
 * Assumes both ends run on the one sample clock.
 */
`timescale 1ns/1ns
interface sample_bank_if;
    import lane_map_pkg::*;
    instant_t                 samples;
    logic                     sample_valid;
    logic [DEPTH_W-1:0]       depth;
    logic                     restart;
    bank_t                    bank;
    logic                     bank_valid;

    modport gatherer (
        input  samples,
        input  sample_valid,
        input  depth,
        input  restart,
        output bank,
        output bank_valid
    );
    modport mapper (
        output samples,
        output sample_valid,
        output depth,
        output restart,
        input  bank,
        input  bank_valid
    );
endinterface

/* File: design/sample_gatherer.sv */
/*
 * Collects a frame's worth of sampling instants for all four channels and
 * hands the full bank over in one registered copy.
 * Assumes depth stays steady unless restart is raised.
 */
`timescale 1ns/1ns
module sample_gatherer
    import lane_map_pkg::*;
(
    input  wire logic         sys_clk,
    input  wire logic         reset_n,
    sample_bank_if.gatherer   sb
);

    bank_t              fill_r;
    bank_t              fill_nxt;
    bank_t              out_r;
    bank_t              out_nxt;
    logic [DEPTH_W-1:0] count_r;
    logic [DEPTH_W-1:0] count_nxt;
    logic               valid_r;
    logic               valid_nxt;

    // --------------------------------------------------------
    // Fill and hand-over
    // --------------------------------------------------------
    // Every channel writes the same slot, so one bank = same instants
    always_comb begin
        fill_nxt  = fill_r;
        out_nxt   = out_r;
        count_nxt = count_r;
        valid_nxt = 1'b0;
        if (sb.restart) begin
            count_nxt = '0;
        end else if (sb.sample_valid) begin
            for (int c = 0; c < CHANNELS; c++) begin
                fill_nxt[c][count_r[2:0]] = sb.samples[c];
            end
            if (count_r == sb.depth - 4'h1) begin
                count_nxt = '0;
                valid_nxt = 1'b1;
                out_nxt   = fill_nxt;  // Copy keeps the frame stable
            end else begin
                count_nxt = count_r + 4'h1;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            fill_r  <= '0;
            out_r   <= '0;
            count_r <= '0;
            valid_r <= 1'b0;
        end else begin
            fill_r  <= fill_nxt;
            out_r   <= out_nxt;
            count_r <= count_nxt;
            valid_r <= valid_nxt;
        end
    end

    assign sb.bank       = out_r;
    assign sb.bank_valid = valid_r;

endmodule

/* File: design/lane_sample_mapper.sv */
/*
 * Transport mapper: packs channel A to D samples into per-lane frames for
 * ten link formats. Octet 0 of a frame sits in bits 39:32 of a lane word.
 * Assumes samples arrive on sys_clk; the format select is an async pin.
 */
`timescale 1ns/1ns

module lane_sample_mapper
    import lane_map_pkg::*;
(
    input  wire logic                 sys_clk,
    input  wire logic                 reset_n,
    input  wire logic [FMT_W-1:0]     link_format_select,
    input  wire logic                 sample_valid,
    input  wire lane_map_pkg::sample_t sample_a,
    input  wire lane_map_pkg::sample_t sample_b,
    input  wire lane_map_pkg::sample_t sample_c,
    input  wire lane_map_pkg::sample_t sample_d,
    output logic [FRAME_W-1:0]        serial_lane_0,
    output logic [FRAME_W-1:0]        serial_lane_1,
    output logic [FRAME_W-1:0]        serial_lane_2,
    output logic [FRAME_W-1:0]        serial_lane_3,
    output logic [FRAME_W-1:0]        serial_lane_4,
    output logic [FRAME_W-1:0]        serial_lane_5,
    output logic [FRAME_W-1:0]        serial_lane_6,
    output logic [FRAME_W-1:0]        serial_lane_7,
    output logic                      frame_start,
    output logic [LANES-1:0]          lane_enable,
    output logic [OCTET_W-1:0]        frame_octets,
    output logic                      format_bad
);
    import lane_map_pkg::*;

    sample_bank_if sb ();

    logic [FMT_W-1:0]   fmt_meta_r;
    logic [FMT_W-1:0]   fmt_sync_r;
    logic [FMT_W-1:0]   fmt_r;
    lane_set_t          lane_r;
    lane_set_t          lane_nxt;
    logic               start_r;
    logic               start_nxt;
    logic [LANES-1:0]   enable_r;
    logic [LANES-1:0]   enable_nxt;
    logic [OCTET_W-1:0] octets_r;
    logic               bad_r;
    logic               bad_nxt;
    logic [PACK_W-1:0]  pack;
    logic [3:0]         lanes_used;

    // --------------------------------------------------------
    // Format select synchroniser
    // --------------------------------------------------------
    // The select is a strap-like pin, so it is resynchronised first
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            fmt_meta_r <= FMT_RESET;
            fmt_sync_r <= FMT_RESET;
            fmt_r      <= FMT_RESET;
        end else begin
            fmt_meta_r <= link_format_select;
            fmt_sync_r <= fmt_meta_r;
            fmt_r      <= fmt_sync_r;
        end
    end

    // --------------------------------------------------------
    // Gatherer hookup
    // --------------------------------------------------------
    // A format change drops the partial bank; mixing depths would tear
    // frames across sampling instants.
    assign sb.samples      = '{sample_d, sample_c, sample_b, sample_a};
    assign sb.sample_valid = sample_valid;
    assign sb.depth        = depth_of(fmt_r);
    assign bad_nxt         = (fmt_r >= FMT_COUNT);
    assign sb.restart      = (fmt_sync_r != fmt_r) || bad_nxt;

    sample_gatherer u_gather (
        .sys_clk (sys_clk),
        .reset_n (reset_n),
        .sb      (sb.gatherer)
    );

    // --------------------------------------------------------
    // Lane mapping
    // --------------------------------------------------------
    // Packed formats share one left-justified stream cut into 16-bit
    // slices; the rest are built per channel.
    always_comb begin
        lane_nxt   = lane_r;
        start_nxt  = 1'b0;
        lanes_used = lanes_of(fmt_r);
        pack       = '0;
        for (int l = 0; l < LANES; l++) begin
            enable_nxt[l] = (l < int'(lanes_used));
        end
        if (sb.restart) begin
            lane_nxt = '0;
        end else if (sb.bank_valid) begin
            start_nxt = 1'b1;
            lane_nxt  = '0;
            case (fmt_r)
                FMT_R12_8B_L6, FMT_R12_64B_L6: begin
                    for (int c = 0; c < CHANNELS; c++) begin
                        pack[PACK_W-1-24*c -: 24] =
                            {sb.bank[c][0], sb.bank[c][1]};
                    end
                end
                FMT_R12_64B_L3: begin
                    for (int c = 0; c < CHANNELS; c++) begin
                        pack[PACK_W-1-SAMPLE_W*c -: SAMPLE_W] = sb.bank[c][0];
                    end
                end
                FMT_R8_64B_L2: begin
                    for (int c = 0; c < CHANNELS; c++) begin
                        pack[PACK_W-1-8*c -: 8] = cut8(sb.bank[c][0]);
                    end
                end
                FMT_R8_8B_L4, FMT_R8_64B_L4: begin
                    for (int c = 0; c < CHANNELS; c++) begin
                        lane_nxt[c] = {cut8(sb.bank[c][0]), 32'h0};
                    end
                end
                FMT_R10_8B_L4: begin
                    for (int c = 0; c < CHANNELS; c++) begin
                        lane_nxt[c] = {cut10(sb.bank[c][0]),
                                       cut10(sb.bank[c][1]),
                                       cut10(sb.bank[c][2]),
                                       cut10(sb.bank[c][3])};
                    end
                end
                FMT_R12_64B_L4: begin
                    for (int c = 0; c < CHANNELS; c++) begin
                        lane_nxt[c] = {sb.bank[c][0], sb.bank[c][1], 16'h0};
                    end
                end
                FMT_R8_8B_L8: begin
                    for (int c = 0; c < CHANNELS; c++) begin
                        for (int k = 0; k < 2; k++) begin
                            lane_nxt[2*c+k] = {cut8(sb.bank[c][k]), 32'h0};
                        end
                    end
                end
                FMT_R10_8B_L8: begin
                    for (int c = 0; c < CHANNELS; c++) begin
                        for (int k = 0; k < 2; k++) begin
                            lane_nxt[2*c+k] = {cut10(sb.bank[c][k]),
                                               cut10(sb.bank[c][k+2]),
                                               cut10(sb.bank[c][k+4]),
                                               cut10(sb.bank[c][k+6])};
                        end
                    end
                end
                default: begin
                    start_nxt = 1'b0;
                end
            endcase
            // Slice the contiguous stream, tail octets left zero
            if (fmt_r == FMT_R12_8B_L6 || fmt_r == FMT_R12_64B_L6 ||
                fmt_r == FMT_R12_64B_L3 || fmt_r == FMT_R8_64B_L2) begin
                for (int l = 0; l < LANES; l++) begin
                    if (l < int'(lanes_used)) begin
                        lane_nxt[l] = {pack[PACK_W-1-SLICE_W*l -: SLICE_W],
                                       24'h0};
                    end
                end
            end
        end
    end

    // Output registers; every lane loads in the same cycle
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            lane_r   <= '0;
            start_r  <= 1'b0;
            enable_r <= '0;
            octets_r <= '0;
            bad_r    <= 1'b0;
        end else begin
            lane_r   <= lane_nxt;
            start_r  <= start_nxt;
            enable_r <= enable_nxt;
            octets_r <= octets_of(fmt_r);
            bad_r    <= bad_nxt;
        end
    end

    // --------------------------------------------------------
    // Port drive
    // --------------------------------------------------------
    assign serial_lane_0 = lane_r[0];
    assign serial_lane_1 = lane_r[1];
    assign serial_lane_2 = lane_r[2];
    assign serial_lane_3 = lane_r[3];
    assign serial_lane_4 = lane_r[4];
    assign serial_lane_5 = lane_r[5];
    assign serial_lane_6 = lane_r[6];
    assign serial_lane_7 = lane_r[7];
    assign frame_start   = start_r;
    assign lane_enable   = enable_r;
    assign frame_octets  = octets_r;
    assign format_bad    = bad_r;

endmodule

/* File: verif/lane_map_monitor.sv */
/*
 * Port-level checker for the lane mapper.
 * Assumes one clock and a synchronous active-low reset.
 */
`timescale 1ns/1ns
module lane_map_monitor
    import lane_map_pkg::*;
(
    input wire logic                  sys_clk,
    input wire logic                  reset_n,
    input wire logic                  sample_valid,
    input wire lane_map_pkg::sample_t sample_a,
    input wire lane_map_pkg::sample_t sample_c,
    input wire lane_map_pkg::sample_t sample_d,
    input wire logic [FRAME_W-1:0]    serial_lane_0,
    input wire logic [FRAME_W-1:0]    serial_lane_1,
    input wire logic [FRAME_W-1:0]    serial_lane_3,
    input wire logic [FRAME_W-1:0]    serial_lane_7,
    input wire logic                  frame_start,
    input wire logic [LANES-1:0]      lane_enable,
    input wire logic [OCTET_W-1:0]    frame_octets,
    input wire logic                  format_bad
);
    // ------------------------------------------------------------
    // Frame checks; frames trail their last sample by two edges
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    bad_code_idle_a: assert property (
        format_bad |-> !frame_start && lane_enable == 8'h00)
        else $error("bad format code still shows lane activity");
    low_lanes_only_a: assert property (
        ((lane_enable + 8'h01) & lane_enable) == 8'h00)
        else $error("enabled lanes are not the lowest ones");
    six_lane_octets_a: assert property (
        frame_start && lane_enable == 8'h3F |-> frame_octets == 3'h2)
        else $error("six-lane frame not two octets");
    tail_zero_a: assert property (
        frame_start && frame_octets == 3'h1
        |-> serial_lane_0[31:0] == 32'h0 && serial_lane_3[31:0] == 32'h0)
        else $error("tail bits of one-octet frame not zero");
    unused_zero_a: assert property (
        frame_start && !lane_enable[7] |-> serial_lane_7 == 40'h0)
        else $error("powered-down lane carries data");
    frame_after_sample_a: assert property (
        frame_start |-> $past(sample_valid, 2))
        else $error("frame without a sample two edges back");
    quad_octet_lane_a: assert property (
        frame_start && lane_enable == 8'h0F && frame_octets == 3'h1
        |-> serial_lane_0[39:32] == 8'($past(sample_a, 2) >> 4))
        else $error("lane 0 octet is not channel A");
    two_lane_pack_a: assert property (
        frame_start && lane_enable == 8'h03 |-> serial_lane_1[39:24] ==
        {8'($past(sample_c, 2) >> 4), 8'($past(sample_d, 2) >> 4)})
        else $error("lane 1 is not C then D");
    three_lane_a: assert property (
        frame_start && lane_enable == 8'h07 |-> frame_octets == 3'h2
        && serial_lane_0[39:28] == $past(sample_a, 2))
        else $error("three-lane frame does not open with A");
endmodule

bind lane_sample_mapper lane_map_monitor u_lane_map_monitor (
    .sys_clk, .reset_n, .sample_valid, .sample_a, .sample_c, .sample_d,
    .serial_lane_0, .serial_lane_1, .serial_lane_3, .serial_lane_7,
    .frame_start, .lane_enable, .frame_octets, .format_bad
);

/* File: verif/lane_rx_model.sv */
/*
 * Receiving logic model: grabs all eight lane words at each frame.
 * Assumes frame_start marks a complete set of lane words.
 */
`timescale 1ns/1ns
module lane_rx_model
    import lane_map_pkg::*;
(
    input  wire logic                    sys_clk,
    input  wire logic                    frame_start,
    input  wire lane_map_pkg::lane_set_t lanes,
    output lane_map_pkg::lane_set_t      lane_cap_r,
    output logic [15:0]                  frame_count_r
);
    initial frame_count_r = 16'h0000;

    // Disabled lanes are latched too, so stray data cannot hide
    always @(posedge sys_clk) begin
        if (frame_start) begin
            lane_cap_r    <= lanes;
            frame_count_r <= frame_count_r + 16'h0001;
        end
    end
endmodule

/* File: verif/lane_sample_mapper_bench.sv */
/*
 * Self-checking bench for the lane mapper with a receiving model.
 * Assumes select is steady before samples start.
 */
`timescale 1ns/1ns
module lane_sample_mapper_bench;
    import lane_map_pkg::*;

    // ------------------------------------------------------------
    // Stimulus and observation
    // ------------------------------------------------------------
    logic              sys_clk            = 1'b0;
    logic              reset_n            = 1'b0;
    logic [FMT_W-1:0]  link_format_select = 4'h0;
    logic              sample_valid       = 1'b0;
    sample_t           sample_a           = 12'h000;
    sample_t           sample_b           = 12'h000;
    sample_t           sample_c           = 12'h000;
    sample_t           sample_d           = 12'h000;
    wire lane_set_t    lanes;
    lane_set_t         cap;
    logic [15:0]       frames;
    logic              frame_start;
    logic [LANES-1:0]  lane_enable;
    logic [OCTET_W-1:0] frame_octets;
    logic              format_bad;
    int                fails   = 0;
    int                n_tests = 0;
    int                dep[10] = '{2, 2, 1, 1, 4, 1, 1, 2, 2, 8};
    int                nln[10] = '{6, 6, 4, 4, 4, 3, 2, 4, 8, 8};
    int                oct[10] = '{2, 2, 1, 1, 5, 2, 2, 3, 1, 5};

    lane_sample_mapper u_lane_sample_mapper (
        .sys_clk, .reset_n, .link_format_select, .sample_valid,
        .sample_a, .sample_b, .sample_c, .sample_d,
        .serial_lane_0(lanes[0]), .serial_lane_1(lanes[1]),
        .serial_lane_2(lanes[2]), .serial_lane_3(lanes[3]),
        .serial_lane_4(lanes[4]), .serial_lane_5(lanes[5]),
        .serial_lane_6(lanes[6]), .serial_lane_7(lanes[7]),
        .frame_start, .lane_enable, .frame_octets, .format_bad
    );
    lane_rx_model u_lane_rx_model (
        .sys_clk, .frame_start, .lanes,
        .lane_cap_r(cap), .frame_count_r(frames)
    );

    // 25 MHz clock
    always #20 sys_clk = ~sys_clk;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Distinct sample per channel and instant
    function automatic sample_t smp(int c, int n);
        return 12'h5A3 ^ 12'(c * 12'h301) ^ 12'(n * 12'h0B7);
    endfunction

    // Expected lane word for frame whose first instant is b
    function automatic lane_word_t exp_lane(int f, int l, int b);
        logic [95:0] st;
        st = '0;
        exp_lane = '0;
        case (f)
            0, 1: for (int i = 0; i < 8; i++) begin
                st[95-12*i -: 12] = smp(i / 2, b + i % 2);
            end
            5: for (int i = 0; i < 4; i++) begin
                st[95-12*i -: 12] = smp(i, b);
            end
            6: for (int i = 0; i < 4; i++) begin
                st[95-8*i -: 8] = 8'(smp(i, b) >> 4);
            end
            2, 3: if (l < 4) begin
                exp_lane[39:32] = 8'(smp(l, b) >> 4);
            end
            4: for (int k = 0; k < 4 && l < 4; k++) begin
                exp_lane[39-10*k -: 10] = 10'(smp(l, b + k) >> 2);
            end
            7: for (int k = 0; k < 2 && l < 4; k++) begin
                exp_lane[39-12*k -: 12] = smp(l, b + k);
            end
            8: exp_lane[39:32] = 8'(smp(l / 2, b + l % 2) >> 4);
            9: for (int k = 0; k < 4; k++) begin
                exp_lane[39-10*k -: 10] =
                    10'(smp(l / 2, b + l % 2 + 2 * k) >> 2);
            end
            default: ;
        endcase
        if ((f < 2 || f == 5 || f == 6) && l < nln[f]) begin
            exp_lane[39:24] = st[95-16*l -: 16];
        end
    endfunction

    task automatic chk_word(string nm, lane_word_t e, lane_word_t g);
        n_tests++;
        if (g !== e) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic chk_bits(string nm, logic [7:0] e, logic [7:0] g);
        n_tests++;
        if (g !== e) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic do_reset(logic [FMT_W-1:0] code, int cyc);
        @(posedge sys_clk);
        #1;
        reset_n = 1'b0;
        link_format_select = code;
        repeat (cyc) @(posedge sys_clk);
        #1;
        reset_n = 1'b1;
        repeat (6) @(posedge sys_clk);
    endtask

    // Back-to-back sampling instants from index b
    task automatic send(int b, int n);
        for (int i = 0; i < n; i++) begin
            @(posedge sys_clk);
            #1;
            sample_valid = 1'b1;
            sample_a = smp(0, b + i);
            sample_b = smp(1, b + i);
            sample_c = smp(2, b + i);
            sample_d = smp(3, b + i);
        end
        @(posedge sys_clk);
        #1;
        sample_valid = 1'b0;
    endtask

    task automatic get_frame();
        logic [15:0] last;
        int          t;
        last = frames;
        t = 0;
        while (frames === last && t < 40) begin
            @(posedge sys_clk);
            #1;
            t++;
        end
        if (t >= 40) begin
            fails++;
            $display("[FAIL] frame_start expected 1 seen 0");
        end
    endtask

    task automatic check_frame(int f, int b);
        for (int l = 0; l < 8; l++) begin
            chk_word("serial_lane", exp_lane(f, l, b), cap[l]);
        end
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic test_formats();
        for (int f = 0; f < 10; f++) begin
            do_reset(4'(f), 2);
            fork
                send(0, 2 * dep[f]);
                begin
                    get_frame();
                    check_frame(f, 0);
                    get_frame();
                    check_frame(f, dep[f]);
                end
            join
            chk_bits("lane_enable", 8'((1 << nln[f]) - 1), lane_enable);
            chk_bits("frame_octets", 8'(oct[f]), {5'h0, frame_octets});
        end
        $display("test_formats done");
    endtask

    task automatic test_bad_code();
        logic [15:0] last;
        for (int c = 10; c < 16; c++) begin
            do_reset(4'(c), 2);
            last = frames;
            send(0, 4);
            repeat (4) @(posedge sys_clk);
            #1;
            chk_bits("format_bad", 8'h01, {7'h0, format_bad});
            chk_bits("lane_enable", 8'h00, lane_enable);
            chk_word("frame_count", 40'(last), 40'(frames));
        end
        $display("test_bad_code done");
    endtask

    // Partial frame dropped on a live format change
    task automatic test_live_change();
        do_reset(4'h4, 2);
        fork
            send(0, 6);
            get_frame();
        join
        check_frame(4, 0);
        link_format_select = 4'h7;
        repeat (6) @(posedge sys_clk);
        #1;
        chk_word("serial_lane_0", 40'h0, lanes[0]);
        chk_bits("frame_octets", 8'h03, {5'h0, frame_octets});
        fork
            send(20, 2);
            get_frame();
        join
        check_frame(7, 20);
        $display("test_live_change done");
    endtask

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    initial begin
        do_reset(4'h0, 10);
        test_formats();
        test_bad_code();
        test_live_change();
        wrap_up();
    end

    // Watchdog: tests need about 320 cycles, so 4000 means a hang
    initial begin
        repeat (4000) @(posedge sys_clk);
        fails++;
        $display("[FAIL] watchdog expected finish seen hang");
        wrap_up();
    end
endmodule
